// >>> hw/sspg_map.svh
// constant map for the start-up, soft-start and output-ok sequencer
`ifndef SSPG_MAP_SVH
`define SSPG_MAP_SVH
// register offsets (word addresses)
`define SSPG_REG_CTRL 4'h0
`define SSPG_REG_DELAY 4'h1
`define SSPG_REG_RAMP 4'h2
`define SSPG_REG_OKDLY 4'h3
`define SSPG_REG_WINLO 4'h4
`define SSPG_REG_WINHI 4'h5
`define SSPG_REG_STATUS 4'h6
`define SSPG_REG_TARGET 4'h7
`define SSPG_REG_REF 4'h8
// ctrl fields
`define SSPG_CTRL_RELOAD 0
`define SSPG_CTRL_PRECISE 1
`define SSPG_CTRL_POL 2
`define SSPG_CTRL_OKSEL 3
// timing
`define SSPG_CLK_KHZ 32'd50000
`define SSPG_TICK_CYC `SSPG_CLK_KHZ
`define SSPG_MIN_DLY_MS 16'd2
`define SSPG_CHECK_MS 16'd5
`define SSPG_RES_STEP_MS 16'd10
`define SSPG_MAX_RES_CODE 5'h14
// window defaults in per mille of target, then target default and zero constant
`define SSPG_WINLO_RST 16'h0064
`define SSPG_WINHI_RST 16'h0096
`define SSPG_TARGET_RST 16'h0400
`define SSPG_ZERO16 16'h0000
`endif

// >>> hw/sspg_pkg.sv
// types for the start-up, soft-start and output-ok sequencer
package sspg_pkg;
  typedef enum logic [1:0] {LVL_LOW, LVL_OPEN, LVL_HIGH, LVL_RES} sspg_lvl_t;
  typedef enum {ST_CHECK, ST_STRAP, ST_READY, ST_DELAY, ST_RAMP, ST_ON} sspg_state_t;
  typedef struct packed {
    sspg_lvl_t lvl;
    logic [4:0] res_code;
  } sspg_strap_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } sspg_bus_t;
  typedef struct packed {
    sspg_state_t st;
    logic [1:0] en_sync;
    logic [15:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic [15:0] ms_goal;
    logic [15:0] delay_ms;
    logic [15:0] ramp_ms;
    logic [15:0] okdly_ms;
    logic okdly_custom;
    logic [15:0] winlo;
    logic [15:0] winhi;
    logic [15:0] target;
    logic [15:0] ref_v;
    logic [15:0] ok_cnt;
    logic precise;
    logic pol;
    logic ok;
    logic ok_pin;
    logic ready;
    logic nvm_req;
    logic [15:0] rdata;
  } sspg_state_s_t;
endpackage : sspg_pkg

// >>> hw/sspg_seq.sv
// start-up sequencer with pre-ramp delay, soft-start ramp and output-ok flag
`timescale 1ns/1ps
`default_nettype none
`include "sspg_map.svh"

// Behaviour
// - after power-up run a 5-10 ms settings check ignoring enable and bus
// - load stored values during check, then sample strap pins and load them only when no stored values are valid
// - reload command repeats the stored-settings check
// - bus and enable accepted only after check and strap sampling
// - pre-ramp delay at least 2 ms; longer configured delay waited fully
// - delay timer starts when enable is asserted
// - coarse/fine strap grid selects 0,1,2,5,10,20,50,100,200 ms delay
// - ramp strap low/open/high gives 0, 5, 10 ms
// - after delay the output ramps monotonically at the configured slope
// - resistor on fine delay or ramp pin gives 0-200 ms in 10 ms steps
// - straps measured only at start-up or reload
// - bus may overwrite delay and ramp with arbitrary values
// - zero ramp drives reference straight to target
// - precise delay timing only when its configuration bit is set
// - output-ok only within window of target and with no fault
// - bus may reprogram window limits and output-ok polarity
// - output-ok held off by delay, default equal to ramp strap time or to the last bus ramp write
// - output-ok hold-off may be programmed independently
module sspg_seq #(
  parameter int unsigned TICK_CYC = `SSPG_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic enable_i,
  input wire sspg_pkg::sspg_strap_t wait_strap_fine_i,
  input wire sspg_pkg::sspg_strap_t wait_strap_coarse_i,
  input wire sspg_pkg::sspg_strap_t ramp_strap_i,
  input wire logic nvm_valid_i,
  input wire logic [15:0] nvm_delay_i,
  input wire logic [15:0] nvm_ramp_i,
  input wire logic [15:0] vout_meas_i,
  input wire logic fault_i,
  input wire sspg_pkg::sspg_bus_t bus_i,
  output logic [15:0] bus_rdata_o,
  output logic [15:0] vref_o,
  output logic ready_o,
  output logic output_ok_flag_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] grid_ms(input sspg_pkg::sspg_lvl_t row,
                                         input sspg_pkg::sspg_lvl_t col);
    logic [15:0] base;
    base = 16'h0001;
    if (row == sspg_pkg::LVL_OPEN || row == sspg_pkg::LVL_HIGH) begin
      base = (row == sspg_pkg::LVL_OPEN) ? 16'h0005 : 16'h0032;
      if (col == sspg_pkg::LVL_OPEN) begin
        grid_ms = 16'(base << 1);
      end else if (col == sspg_pkg::LVL_HIGH) begin
        grid_ms = 16'(base << 2);
      end else begin
        grid_ms = base;
      end
    end else begin
      // low row; a resistor on the coarse pin falls back to it
      if (col == sspg_pkg::LVL_OPEN) begin
        grid_ms = base;
      end else if (col == sspg_pkg::LVL_HIGH) begin
        grid_ms = 16'(base << 1);
      end else begin
        grid_ms = `SSPG_ZERO16;
      end
    end
  endfunction : grid_ms

  function automatic logic [15:0] res_ms(input logic [4:0] code);
    logic [4:0] c;
    c = (code > `SSPG_MAX_RES_CODE) ? `SSPG_MAX_RES_CODE : code;
    res_ms = 16'(c * `SSPG_RES_STEP_MS);
  endfunction : res_ms

  function automatic logic [15:0] ramp_ms_of(input sspg_pkg::sspg_strap_t s);
    if (s.lvl == sspg_pkg::LVL_RES) begin
      ramp_ms_of = res_ms(s.res_code);
    end else if (s.lvl == sspg_pkg::LVL_OPEN) begin
      ramp_ms_of = 16'h0005;
    end else if (s.lvl == sspg_pkg::LVL_HIGH) begin
      ramp_ms_of = 16'h000A;
    end else begin
      ramp_ms_of = `SSPG_ZERO16;
    end
  endfunction : ramp_ms_of

  function automatic logic [15:0] scale(input logic [15:0] v, input logic [15:0] pm);
    logic [31:0] p;
    p = 32'(v) * 32'(pm);
    scale = 16'(p / 32'd1000);
  endfunction : scale

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  sspg_pkg::sspg_state_s_t r;
  sspg_pkg::sspg_state_s_t next_r;
  logic ms_tick;
  logic en_now;
  logic in_win;
  logic [15:0] lo_lim;
  logic [15:0] hi_lim;
  logic [15:0] eff_dly;
  logic [15:0] tick_top;
  logic [31:0] ramp_prod;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    en_now = r.en_sync[1];
    // one tick per ms; ordinary timing lets the first ms be partial
    tick_top = 16'(TICK_CYC - 32'd1);
    ms_tick = 1'b0;
    if (r.tick_cnt >= tick_top) begin
      next_r.tick_cnt = `SSPG_ZERO16;
      ms_tick = 1'b1;
    end else begin
      next_r.tick_cnt = 16'(r.tick_cnt + 16'h0001);
    end
    next_r.en_sync = {r.en_sync[0], enable_i};
    eff_dly = (r.delay_ms < `SSPG_MIN_DLY_MS) ? `SSPG_MIN_DLY_MS : r.delay_ms;
    lo_lim = 16'(r.target - scale(r.target, r.winlo));
    hi_lim = 16'(r.target + scale(r.target, r.winhi));
    in_win = (vout_meas_i >= lo_lim) && (vout_meas_i <= hi_lim);
    ramp_prod = 32'(r.target) * 32'(r.ms_cnt);
    next_r.rdata = `SSPG_ZERO16;

    case (r.st)
      sspg_pkg::ST_CHECK: begin
        next_r.ref_v = `SSPG_ZERO16;
        next_r.ok = 1'b0;
        if (r.nvm_req && nvm_valid_i) begin
          next_r.delay_ms = nvm_delay_i;
          next_r.ramp_ms = nvm_ramp_i;
          next_r.nvm_req = 1'b0;
        end
        if (ms_tick) begin
          next_r.ms_cnt = 16'(r.ms_cnt + 16'h0001);
        end
        if (r.ms_cnt >= `SSPG_CHECK_MS) begin
          next_r.st = sspg_pkg::ST_STRAP;
        end
      end
      sspg_pkg::ST_STRAP: begin
        if (!r.okdly_custom) begin
          next_r.okdly_ms = ramp_ms_of(ramp_strap_i);
        end
        if (!nvm_valid_i) begin
          if (wait_strap_fine_i.lvl == sspg_pkg::LVL_RES) begin
            next_r.delay_ms = res_ms(wait_strap_fine_i.res_code);
          end else begin
            next_r.delay_ms = grid_ms(wait_strap_coarse_i.lvl, wait_strap_fine_i.lvl);
          end
          next_r.ramp_ms = ramp_ms_of(ramp_strap_i);
        end
        next_r.st = sspg_pkg::ST_READY;
      end
      sspg_pkg::ST_READY: begin
        next_r.ref_v = `SSPG_ZERO16;
        next_r.ok = 1'b0;
        next_r.ms_cnt = `SSPG_ZERO16;
        if (en_now) begin
          next_r.st = sspg_pkg::ST_DELAY;
          next_r.tick_cnt = `SSPG_ZERO16;
        end
      end
      sspg_pkg::ST_DELAY: begin
        if (ms_tick) begin
          next_r.ms_cnt = 16'(r.ms_cnt + 16'h0001);
        end
        if (!en_now) begin
          next_r.st = sspg_pkg::ST_READY;
        end else if (r.ms_cnt >= eff_dly) begin
          next_r.st = sspg_pkg::ST_RAMP;
          next_r.ms_cnt = `SSPG_ZERO16;
        end
      end
      sspg_pkg::ST_RAMP: begin
        if (ms_tick) begin
          next_r.ms_cnt = 16'(r.ms_cnt + 16'h0001);
        end
        if (!en_now) begin
          next_r.st = sspg_pkg::ST_READY;
        end else if (r.ramp_ms == `SSPG_ZERO16 || r.ms_cnt >= r.ramp_ms) begin
          next_r.ref_v = r.target;
          next_r.st = sspg_pkg::ST_ON;
          next_r.ok_cnt = `SSPG_ZERO16;
        end else begin
          next_r.ref_v = 16'(ramp_prod / 32'(r.ramp_ms));
        end
      end
      sspg_pkg::ST_ON: begin
        next_r.ref_v = r.target;
        if (!en_now) begin
          next_r.st = sspg_pkg::ST_READY;
          next_r.ok = 1'b0;
        end else if (in_win && !fault_i) begin
          if (r.ok_cnt >= r.okdly_ms) begin
            next_r.ok = 1'b1;
          end else if (ms_tick) begin
            next_r.ok_cnt = 16'(r.ok_cnt + 16'h0001);
          end
        end else begin
          next_r.ok = 1'b0;
          next_r.ok_cnt = `SSPG_ZERO16;
        end
      end
      default: begin
        next_r.st = sspg_pkg::ST_CHECK;
      end
    endcase

    // bus access, ignored until ready
    if (r.st != sspg_pkg::ST_CHECK && r.st != sspg_pkg::ST_STRAP) begin
      if (bus_i.wr) begin
        if (bus_i.addr == `SSPG_REG_CTRL) begin
          next_r.precise = bus_i.wdata[`SSPG_CTRL_PRECISE];
          next_r.pol = bus_i.wdata[`SSPG_CTRL_POL];
          next_r.okdly_custom = bus_i.wdata[`SSPG_CTRL_OKSEL];
          if (bus_i.wdata[`SSPG_CTRL_RELOAD]) begin
            next_r.st = sspg_pkg::ST_CHECK;
            next_r.ms_cnt = `SSPG_ZERO16;
            next_r.tick_cnt = `SSPG_ZERO16;
            next_r.nvm_req = 1'b1;
            next_r.ref_v = `SSPG_ZERO16;
            next_r.ok = 1'b0;
          end
        end else if (bus_i.addr == `SSPG_REG_DELAY) begin
          next_r.delay_ms = bus_i.wdata;
        end else if (bus_i.addr == `SSPG_REG_RAMP) begin
          next_r.ramp_ms = bus_i.wdata;
          if (!r.okdly_custom) begin
            next_r.okdly_ms = bus_i.wdata;
          end
        end else if (bus_i.addr == `SSPG_REG_OKDLY) begin
          next_r.okdly_ms = bus_i.wdata;
          next_r.okdly_custom = 1'b1;
        end else if (bus_i.addr == `SSPG_REG_WINLO) begin
          next_r.winlo = bus_i.wdata;
        end else if (bus_i.addr == `SSPG_REG_WINHI) begin
          next_r.winhi = bus_i.wdata;
        end else if (bus_i.addr == `SSPG_REG_TARGET) begin
          next_r.target = bus_i.wdata;
        end
      end
      if (bus_i.rd) begin
        if (bus_i.addr == `SSPG_REG_CTRL) begin
          next_r.rdata = {12'h000, r.okdly_custom, r.pol, r.precise, 1'b0};
        end else if (bus_i.addr == `SSPG_REG_DELAY) begin
          next_r.rdata = r.delay_ms;
        end else if (bus_i.addr == `SSPG_REG_RAMP) begin
          next_r.rdata = r.ramp_ms;
        end else if (bus_i.addr == `SSPG_REG_OKDLY) begin
          next_r.rdata = r.okdly_ms;
        end else if (bus_i.addr == `SSPG_REG_WINLO) begin
          next_r.rdata = r.winlo;
        end else if (bus_i.addr == `SSPG_REG_WINHI) begin
          next_r.rdata = r.winhi;
        end else if (bus_i.addr == `SSPG_REG_STATUS) begin
          next_r.rdata = {12'h000, r.ok, 3'(r.st)};
        end else if (bus_i.addr == `SSPG_REG_TARGET) begin
          next_r.rdata = r.target;
        end else if (bus_i.addr == `SSPG_REG_REF) begin
          next_r.rdata = r.ref_v;
        end
      end
    end
    // precise mode restarts the ms tick exactly at enable; ordinary keeps free tick
    if (r.st == sspg_pkg::ST_READY && en_now && !r.precise) begin
      next_r.tick_cnt = ms_tick ? `SSPG_ZERO16 : 16'(r.tick_cnt + 16'h0001);
    end
    next_r.ok_pin = next_r.ok ^ r.pol;
    next_r.ready = (next_r.st != sspg_pkg::ST_CHECK) && (next_r.st != sspg_pkg::ST_STRAP);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r <= '0;
      r.st <= sspg_pkg::ST_CHECK;
      r.nvm_req <= 1'b1;
      r.winlo <= `SSPG_WINLO_RST;
      r.winhi <= `SSPG_WINHI_RST;
      r.target <= `SSPG_TARGET_RST;
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

  assign bus_rdata_o = r.rdata;
  assign vref_o = r.ref_v;
  assign ready_o = r.ready;
  assign output_ok_flag_o = r.ok_pin;

endmodule : sspg_seq
`default_nettype wire

// >>> verif/sspg_load_model.sv
// load model: measured output follows the reference at a set fraction
`timescale 1ns/1ps
`default_nettype none
module sspg_load_model (
  input wire logic clk_i,
  input wire logic [15:0] vref_i,
  input wire logic [9:0] permil_i,
  output logic [15:0] vout_o
);
  // ------------------------
  // output tracks reference
  // ------------------------
  always_ff @(posedge clk_i) begin
    vout_o <= 16'((32'(vref_i) * 32'(permil_i)) / 32'd1000);
  end
endmodule : sspg_load_model
`default_nettype wire

// >>> verif/sspg_seq_props.sv
// port checks for the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module sspg_seq_props #(
  parameter int unsigned TICK_CYC = 50000
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire logic fault_i,
  input wire sspg_pkg::sspg_bus_t bus_i,
  input wire logic [15:0] bus_rdata_o,
  input wire logic [15:0] vref_o,
  input wire logic ready_o,
  input wire logic output_ok_flag_o
);
  // -------------------
  // not-ready counter
  // -------------------
  int unsigned low_cnt;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || ready_o) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  check_time_a: assert property ($rose(ready_o) |-> low_cnt >= 5 * TICK_CYC && low_cnt <= 10 * TICK_CYC)
    else $error("ready outside check time");
  idle_ref_a: assert property (!ready_o |-> vref_o == 16'h0000)
    else $error("reference moved before ready");
  read_idle_a: assert property (!$past(bus_i.rd) |-> bus_rdata_o == 16'h0000)
    else $error("read data without read");
  read_refused_a: assert property ($past(bus_i.rd) && !$past(ready_o) |-> bus_rdata_o == 16'h0000)
    else $error("read answered before ready");
  ramp_mono_a: assert property (enable_i [*8] |-> vref_o >= $past(vref_o))
    else $error("reference fell while enabled");
  step_pace_a: assert property (ready_o && $changed(vref_o) |=> $stable(vref_o) [*8])
    else $error("reference stepped too often");
  ok_ready_a: assert property (!ready_o |-> !output_ok_flag_o)
    else $error("output ok before ready");
  ok_fault_a: assert property (fault_i [*6] |-> !output_ok_flag_o)
    else $error("output ok during fault");
  ok_holdoff_a: assert property ($rose(output_ok_flag_o) |-> $past(vref_o, 3) == vref_o)
    else $error("output ok without hold-off");
endmodule : sspg_seq_props
bind sspg_seq sspg_seq_props #(.TICK_CYC(TICK_CYC)) u_props (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i), .fault_i(fault_i),
  .bus_i(bus_i), .bus_rdata_o(bus_rdata_o), .vref_o(vref_o), .ready_o(ready_o),
  .output_ok_flag_o(output_ok_flag_o)
);
`default_nettype wire

// >>> verif/test_startup_softstart_powergood_seq.sv
// self-checking bench for the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sspg_map.svh"
module test_startup_softstart_powergood_seq;
  localparam int MS = 50;
  localparam int CK = 5 * MS;
  logic clk_i = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic flt = 1'b0;
  logic nvm_v = 1'b0;
  logic [9:0] permil = 10'd1000;
  sspg_pkg::sspg_strap_t fine, coarse, ramp;
  sspg_pkg::sspg_bus_t bus = '0;
  logic [15:0] rdata, vref, vout, seen_v;
  logic ready, okf;
  int mismatches = 0;
  int checks = 0;
  int n;
  sspg_seq #(.TICK_CYC(MS)) DUT (.clk_i(clk_i), .sys_rst_i(rst), .clk_en_i(1'b1),
    .enable_i(en),
    .wait_strap_fine_i(fine), .wait_strap_coarse_i(coarse), .ramp_strap_i(ramp),
    .nvm_valid_i(nvm_v), .nvm_delay_i(16'h0007), .nvm_ramp_i(16'h0003),
    .vout_meas_i(vout), .fault_i(flt), .bus_i(bus), .bus_rdata_o(rdata),
    .vref_o(vref), .ready_o(ready), .output_ok_flag_o(okf));
  sspg_load_model u_load (.clk_i(clk_i), .vref_i(vref), .permil_i(permil), .vout_o(vout));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // -------------
  // shared tasks
  // -------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rng(input string what, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : rng
  function automatic logic cond(input int c);
    case (c)
      0: return ready === 1'b1;
      1: return vref !== 16'h0000;
      2: return vref === `SSPG_TARGET_RST;
      3: return okf === 1'b1;
      4: return vref === 16'h0000;
      default: return ready === 1'b0;
    endcase
  endfunction : cond
  // counts cycles until the condition holds, ends on a rising edge
  task automatic wait_on(input int c, input int lim);
    n = 0;
    do begin
      @(negedge clk_i);
      seen_v = vref;
      n++;
    end while (!cond(c) && n < lim);
    if (!cond(c)) begin
      mismatches++;
      $display("mismatch wait %0d expected done seen timeout", c);
      close_out();
    end
    @(posedge clk_i);
  endtask : wait_on
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus <= '0;
  endtask : wr
  task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus <= '0;
    @(negedge clk_i);
    chk(what, exp, rdata);
  endtask : rchk
  task automatic reload();
    wr(`SSPG_REG_CTRL, 16'h0001);
    wait_on(5, 10);
    wait_on(0, 2 * CK);
  endtask : reload
  // ---------------
  // main sequence
  // ---------------
  initial begin
    fine = '{sspg_pkg::LVL_OPEN, 5'h00};
    coarse = '{sspg_pkg::LVL_LOW, 5'h00};
    ramp = '{sspg_pkg::LVL_HIGH, 5'h00};
    repeat (12) @(posedge clk_i);
    rst <= 1'b0;
    rchk("early read", `SSPG_REG_TARGET, 16'h0000);
    @(posedge clk_i);
    en <= 1'b1;
    repeat (MS) @(posedge clk_i);
    en <= 1'b0;
    wait_on(0, 2 * CK);
    rng("check time", CK, 2 * CK, n + MS + 3);
    rchk("idle state", `SSPG_REG_STATUS, 16'h0002);
    rchk("delay strap", `SSPG_REG_DELAY, 16'h0001);
    rchk("ramp strap", `SSPG_REG_RAMP, 16'h000A);
    rchk("low limit", `SSPG_REG_WINLO, `SSPG_WINLO_RST);
    rchk("high limit", `SSPG_REG_WINHI, `SSPG_WINHI_RST);
    rchk("unmapped", 4'hF, 16'h0000);
    $display("test power-up done");
    wr(`SSPG_REG_RAMP, 16'h0004);
    wr(`SSPG_REG_CTRL, 16'h0002);
    en <= 1'b1;
    wait_on(1, 4 * MS);
    rng("pre-ramp delay", 2 * MS, 3 * MS + 200, n);
    chk("first step", 16'h0100, seen_v);
    wait_on(2, 5 * MS);
    rng("ramp time", 3 * MS - 5, 3 * MS + 5, n);
    wait_on(3, 6 * MS);
    rng("ok hold-off", 3 * MS, 4 * MS + 5, n);
    rchk("on state", `SSPG_REG_STATUS, 16'h000D);
    $display("test ramp done");
    permil <= 10'd850;
    repeat (6) @(negedge clk_i);
    chk("out of window", 16'h0000, 16'(okf));
    @(posedge clk_i);
    permil <= 10'd1000;
    flt <= 1'b1;
    repeat (8) @(negedge clk_i);
    chk("fault", 16'h0000, 16'(okf));
    @(posedge clk_i);
    flt <= 1'b0;
    wr(`SSPG_REG_CTRL, 16'h0006);
    repeat (4) @(negedge clk_i);
    chk("inverted pin", 16'h0001, 16'(okf));
    wr(`SSPG_REG_CTRL, 16'h0002);
    $display("test output ok done");
    en <= 1'b0;
    wait_on(4, 20);
    wr(`SSPG_REG_RAMP, 16'h0000);
    wr(`SSPG_REG_OKDLY, 16'h0003);
    en <= 1'b1;
    wait_on(1, 4 * MS);
    chk("zero ramp", `SSPG_TARGET_RST, seen_v);
    wait_on(3, 3 * MS);
    rng("set hold-off", 2 * MS, 3 * MS + 5, n);
    $display("test zero ramp done");
    en <= 1'b0;
    fine <= '{sspg_pkg::LVL_RES, 5'h02};
    ramp <= '{sspg_pkg::LVL_RES, 5'h03};
    wait_on(4, 20);
    rchk("strap held", `SSPG_REG_RAMP, 16'h0000);
    reload();
    rng("reload time", CK - 5, 2 * CK, n);
    rchk("fine resistor", `SSPG_REG_DELAY, 16'h0014);
    rchk("ramp resistor", `SSPG_REG_RAMP, 16'h001E);
    coarse <= '{sspg_pkg::LVL_HIGH, 5'h00};
    fine <= '{sspg_pkg::LVL_OPEN, 5'h00};
    ramp <= '{sspg_pkg::LVL_OPEN, 5'h00};
    reload();
    rchk("grid delay", `SSPG_REG_DELAY, 16'h0064);
    rchk("open ramp", `SSPG_REG_RAMP, 16'h0005);
    nvm_v <= 1'b1;
    reload();
    rchk("stored delay", `SSPG_REG_DELAY, 16'h0007);
    rchk("stored ramp", `SSPG_REG_RAMP, 16'h0003);
    $display("test reload done");
    close_out();
  end
endmodule : test_startup_softstart_powergood_seq
`default_nettype wire
